// *** logic/rnb_pkg.sv ***
// Constants for the nibble bus port of the clock module.
// Assumes a single 100 MHz system clock; all pins are asynchronous to it.
package rnb_pkg;
    localparam int RNB_DATA_W = 4;
    localparam int RNB_IDX_W = 4;
    localparam int RNB_REG_N = 16;
    localparam int RNB_SYNC_STAGES = 3;
    localparam logic [3:0] RNB_NIBBLE_RST = 4'h0;
    localparam logic [3:0] RNB_IDX_RST = 4'h0;
    // Register holding the pause and counter reset bits
    localparam logic [3:0] RNB_CTRL_IDX = 4'hD;
    localparam int RNB_PAUSE_BIT = 1;
    localparam int RNB_CRST_BIT = 0;
    // Pin word layout after the synchronisers
    localparam int RNB_PIN_W = 16;
    localparam int RNB_POS_PG = 15;
    localparam int RNB_POS_CSN = 14;
    localparam int RNB_POS_AH = 13;
    localparam int RNB_POS_RDN = 12;
    localparam int RNB_POS_WRN = 11;
    localparam int RNB_POS_IDX = 4;
    localparam int RNB_POS_DIN = 0;
    // Pins at rest: power gate low, selects and strobes high
    localparam logic [15:0] RNB_PIN_IDLE = 16'h7800;
    localparam logic RNB_CSN_RST = 1'h1;
    localparam logic RNB_WRN_RST = 1'h1;
    localparam logic RNB_PG_RST = 1'h0;
    typedef enum logic [1:0] {RNB_IDLE, RNB_READ, RNB_WRITE} rnb_mode_t;
endpackage

// *** logic/rnb_port.sv ***
// Parallel nibble bus port of a real time clock, with address latch.
// Assumes host pins are asynchronous and are resynchronised here.
//
// Function
// - Selected, powered, read low and write high: data pins are driven.
// - Selected, powered, read high and write low: data pins are inputs.
// - With the power gate low the data pins stay undriven.
// - With power gate high and the passed or latched chip select high the data pins stay undriven.
// - While the address strobe is high, index and chip select pass straight through.
// - When the address strobe falls, index and chip select are held while it stays low.
// - Data is stored into the indexed register at the rising edge of a selected, powered write.
// - During a selected, powered read, the indexed register contents drive the data pins.
// - The four index bits choose one of sixteen internal registers.
// - When the power gate falls, the pause and counter reset bits clear.
`timescale 1ns/1ns
module rnb_port (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic power_gate_select,
    input wire logic chip_select_n,
    input wire logic addr_hold,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [3:0] register_index,
    input wire logic [3:0] nibble_data_in,
    output logic [3:0] nibble_data_out,
    output logic nibble_data_oe,
    output logic count_pause,
    output logic counter_reset
);
    // ********************
    // Synchronisers
    // ********************
    localparam int SW = rnb_pkg::RNB_PIN_W;
    logic [SW-1:0] s1, s2, s3, next_s1, next_s2, next_s3;
    logic pg, csn, ah, rdn, wrn;
    logic [3:0] idx, din;
    logic pg_q, wrn_q, next_pg_q, next_wrn_q;

    // Change counts only when stages two and three agree
    function automatic logic agree(input logic a, input logic b, input logic old);
        agree = (a == b) ? b : old;
    endfunction

    logic [SW-1:0] raw;
    assign raw = {power_gate_select, chip_select_n, addr_hold, rd_n, wr_n,
                  3'h0, register_index, nibble_data_in};

    logic [SW-1:0] filt, next_filt;
    always_comb
    begin
        next_s1 = raw;
        next_s2 = s1;
        next_s3 = s2;
        for (int i = 0; i < SW; i++)
        begin
            next_filt[i] = agree(s2[i], s3[i], filt[i]);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Stages start at the idle pin pattern, so no false strobe edge follows reset
            s1 <= rnb_pkg::RNB_PIN_IDLE;
            s2 <= rnb_pkg::RNB_PIN_IDLE;
            s3 <= rnb_pkg::RNB_PIN_IDLE;
            filt <= rnb_pkg::RNB_PIN_IDLE;
        end
        else
        begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
            filt <= next_filt;
        end
    end

    assign pg = filt[rnb_pkg::RNB_POS_PG];
    assign csn = filt[rnb_pkg::RNB_POS_CSN];
    assign ah = filt[rnb_pkg::RNB_POS_AH];
    assign rdn = filt[rnb_pkg::RNB_POS_RDN];
    assign wrn = filt[rnb_pkg::RNB_POS_WRN];
    assign idx = filt[rnb_pkg::RNB_POS_IDX +: rnb_pkg::RNB_IDX_W];
    assign din = filt[rnb_pkg::RNB_POS_DIN +: rnb_pkg::RNB_DATA_W];

    // ********************
    // Address latch
    // ********************
    logic [3:0] idx_hold, next_idx_hold;
    logic csn_hold, next_csn_hold;
    logic [3:0] eff_idx;
    logic eff_csn;

    always_comb
    begin
        next_idx_hold = idx_hold;
        next_csn_hold = csn_hold;
        // Hold register follows the pins while the strobe is high
        if (ah)
        begin
            next_idx_hold = idx;
            next_csn_hold = csn;
        end
        eff_idx = ah ? idx : idx_hold;
        eff_csn = ah ? csn : csn_hold;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idx_hold <= rnb_pkg::RNB_IDX_RST;
            csn_hold <= rnb_pkg::RNB_CSN_RST;
        end
        else
        begin
            idx_hold <= next_idx_hold;
            csn_hold <= next_csn_hold;
        end
    end

    // ********************
    // Strobe edge detect
    // ********************
    always_comb
    begin
        next_pg_q = pg;
        next_wrn_q = wrn;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pg_q <= rnb_pkg::RNB_PG_RST;
            wrn_q <= rnb_pkg::RNB_WRN_RST;
        end
        else
        begin
            pg_q <= next_pg_q;
            wrn_q <= next_wrn_q;
        end
    end

    // ********************
    // Register file and port control
    // ********************
    logic [3:0] regs [rnb_pkg::RNB_REG_N];
    logic [3:0] next_regs [rnb_pkg::RNB_REG_N];
    logic [3:0] next_dout;
    logic next_oe;
    logic next_count_pause, next_counter_reset;
    rnb_pkg::rnb_mode_t mode;
    logic sel;

    always_comb
    begin
        sel = pg && !eff_csn;
        if (!sel || (!rdn && !wrn))
            mode = rnb_pkg::RNB_IDLE;
        else if (!rdn)
            mode = rnb_pkg::RNB_READ;
        else if (!wrn)
            mode = rnb_pkg::RNB_WRITE;
        else
            mode = rnb_pkg::RNB_IDLE;

        next_regs = regs;
        // Store on the rising write edge that ends a selected write
        if (sel && rdn && !wrn_q && wrn)
        begin
            next_regs[eff_idx] = din;
        end
        if (pg_q && !pg)
        begin
            next_regs[rnb_pkg::RNB_CTRL_IDX][rnb_pkg::RNB_PAUSE_BIT] = 1'b0;
            next_regs[rnb_pkg::RNB_CTRL_IDX][rnb_pkg::RNB_CRST_BIT] = 1'b0;
        end
        // Pause and counter reset mirror their register bits
        next_count_pause = next_regs[rnb_pkg::RNB_CTRL_IDX][rnb_pkg::RNB_PAUSE_BIT];
        next_counter_reset = next_regs[rnb_pkg::RNB_CTRL_IDX][rnb_pkg::RNB_CRST_BIT];

        // Drive only for a selected read; write and idle leave the pins released
        next_oe = 1'b0;
        next_dout = rnb_pkg::RNB_NIBBLE_RST;
        case (mode)
            rnb_pkg::RNB_READ:
            begin
                next_oe = 1'b1;
                next_dout = regs[eff_idx];
            end
            rnb_pkg::RNB_WRITE: next_oe = 1'b0;
            rnb_pkg::RNB_IDLE: next_oe = 1'b0;
            default: next_oe = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nibble_data_out <= rnb_pkg::RNB_NIBBLE_RST;
            nibble_data_oe <= 1'b0;
            count_pause <= 1'b0;
            counter_reset <= 1'b0;
            for (int i = 0; i < rnb_pkg::RNB_REG_N; i++)
            begin
                regs[i] <= rnb_pkg::RNB_NIBBLE_RST;
            end
        end
        else
        begin
            nibble_data_out <= next_dout;
            nibble_data_oe <= next_oe;
            count_pause <= next_count_pause;
            counter_reset <= next_counter_reset;
            regs <= next_regs;
        end
    end
endmodule

// *** tb/rnb_monitor.sv ***
// Checker on the port pins; pins move just after clk_sys rises.
// Assumes it is bound into the port and sees only its pins.
`timescale 1ns/1ns
module rnb_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic power_gate_select,
    input wire logic chip_select_n,
    input wire logic addr_hold,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic nibble_data_oe,
    input wire logic count_pause,
    input wire logic counter_reset
);
    wire oe = nibble_data_oe;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_rd; oe |-> !$past(rd_n, 5); endproperty
    a_rd: assert property (p_rd) else $error("drive without read");
    property p_wr; oe |-> $past(wr_n, 5); endproperty
    a_wr: assert property (p_wr) else $error("drive in write");
    property p_go; (!rd_n && wr_n && power_gate_select && !chip_select_n) [*7] |-> oe;
    endproperty
    a_go: assert property (p_go) else $error("no drive");
    property p_in; !wr_n [*6] |-> !oe; endproperty
    a_in: assert property (p_in) else $error("drive in write");
    property p_pg; !power_gate_select [*6] |-> !oe; endproperty
    a_pg: assert property (p_pg) else $error("drive in standby");
    property p_cs; (chip_select_n && addr_hold) [*6] |-> !oe; endproperty
    a_cs: assert property (p_cs) else $error("drive unselected");
    property p_clr; $fell(power_gate_select) |-> ##[4:7] !(count_pause || counter_reset);
    endproperty
    a_clr: assert property (p_clr) else $error("bits not cleared");
    property p_st; $rose(count_pause) || $rose(counter_reset) |-> !$past(wr_n, 8);
    endproperty
    a_st: assert property (p_st) else $error("bit set without write");
endmodule
bind rnb_port rnb_monitor rnb_monitor_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .power_gate_select(power_gate_select),
    .chip_select_n(chip_select_n),
    .addr_hold(addr_hold),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .nibble_data_oe(nibble_data_oe),
    .count_pause(count_pause),
    .counter_reset(counter_reset)
);

// *** tb/rnb_host.sv ***
// Host bus model; the bench sets the select and latch pins itself.
`timescale 1ns/1ns
module rnb_host (
    input wire logic clk_sys,
    input wire logic nibble_data_oe,
    input wire logic [3:0] nibble_data_out,
    output logic rd_n,
    output logic wr_n,
    output logic [3:0] register_index,
    output logic [3:0] nibble_data_in
);
    logic drv = 1'b0;
    logic [3:0] d = 4'h0;
    initial {rd_n, wr_n, register_index} = 6'h30; // Read and write never low together
    assign nibble_data_in = drv ? d : nibble_data_oe ? nibble_data_out : ~d;
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task wr(input logic [3:0] i, input logic [3:0] v);
        {register_index, d, drv, wr_n} = {i, v, 2'h2};
        cyc(6);
        wr_n = 1'b1;
        cyc(6);
        drv = 1'b0;
        cyc(1);
    endtask
    task rd(input logic [3:0] i);
        {register_index, rd_n} = {i, 1'b0};
        cyc(8);
        rd_n = 1'b1;
        cyc(7);
    endtask
endmodule

// *** tb/tb_top.sv ***
// Bench: host model drives the nibble port; reads are checked from a queue.
`timescale 1ns/1ns
module tb_top;
    logic clk_sys = 1'b0, rst_n = 1'b0, power_gate_select = 1'b1, chip_select_n = 1'b0;
    logic addr_hold = 1'b1, rd_n, wr_n, nibble_data_oe, count_pause, counter_reset;
    logic [3:0] register_index, nibble_data_in, nibble_data_out, m [16], q [$];
    int fails = 0, compares = 0, seed = 32'h27fcb47a;
    rnb_port rnb_port_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .power_gate_select(power_gate_select),
        .chip_select_n(chip_select_n),
        .addr_hold(addr_hold),
        .rd_n(rd_n),
        .wr_n(wr_n),
        .register_index(register_index),
        .nibble_data_in(nibble_data_in),
        .nibble_data_out(nibble_data_out),
        .nibble_data_oe(nibble_data_oe),
        .count_pause(count_pause),
        .counter_reset(counter_reset)
    );
    rnb_host h (
        .clk_sys(clk_sys),
        .nibble_data_oe(nibble_data_oe),
        .nibble_data_out(nibble_data_out),
        .rd_n(rd_n),
        .wr_n(wr_n),
        .register_index(register_index),
        .nibble_data_in(nibble_data_in)
    );
    initial forever #5 clk_sys = ~clk_sys;
    task chk(input logic [3:0] e, input logic [3:0] g);
        compares++;
        fails += (g !== e);
        if (g !== e)
            $display("Error %0t: got %h not %h", $time, g, e);
    endtask
    task chk_ctl(input logic [1:0] e);
        logic [1:0] g;
        g = {count_pause, counter_reset};
        compares++;
        fails += (g !== e);
        if (g !== e)
            $display("Error %0t: control bits %b not %b", $time, g, e);
    endtask
    task summarize;
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(negedge clk_sys)
        if ($rose(nibble_data_oe))
            chk(q.size() ? q.pop_front() : 4'hX, nibble_data_out);
    initial
    begin
        #20000 fails++;
        summarize();
    end
    initial
    begin
        repeat (5) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            m[i] = 4'($random(seed));
            h.wr(4'(i), m[i]);
        end
        h.wr(4'hD, 4'h3);
        chk_ctl(2'h3);
        power_gate_select = 1'b0;
        h.wr(4'h2, ~m[2]);
        h.rd(4'h2);
        chk_ctl(2'h0);
        {m[13], power_gate_select, chip_select_n} = 6'h03;
        h.rd(4'h3);
        h.wr(4'h3, ~m[3]);
        {chip_select_n, h.register_index} = 5'h07;
        h.cyc(6);
        addr_hold = 1'b0;
        h.cyc(6);
        chip_select_n = 1'b1;
        q.push_back(m[7]);
        h.rd(4'h9);
        {addr_hold, chip_select_n} = 2'h2;
        for (int i = 0; i < 16; i++)
        begin
            q.push_back(m[i]);
            h.rd(4'(i));
        end
        summarize();
    end
endmodule
